// ---- core/sram_ctl_pkg.sv ----
// Package of constants and types for the SRAM control-input block
package sram_ctl_pkg;
  localparam int ADDR_W_DEF  = 20;
  localparam int LANES_DEF   = 8;
  localparam int LANE_W      = 9;
  localparam int BURST_W     = 2;
  localparam int DEPTH_DEF   = 16;
  localparam logic RST_ACTIVE = 1'b0;
  localparam logic RST_LOADED = 1'b0;
  localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_e;
endpackage

// ---- core/sram_wr_if.sv ----
// Interface carrying one qualified write from the control logic to the lane array
interface sram_wr_if #(
  parameter int ADDR_W = 20,
  parameter int LANES  = 8
);
  import sram_ctl_pkg::*;
  logic                      we;
  logic [ADDR_W-1:0]         addr;
  logic [LANES-1:0]          lane_en;
  logic [LANES*LANE_W-1:0]   data;
  logic [LANES*LANE_W-1:0]   rdata;
  modport ctl (output we, output addr, output lane_en, output data, input rdata);
  modport mem (input we, input addr, input lane_en, input data, output rdata);
endinterface

// ---- core/sram_lane_array.sv ----
// Flip-flop storage with per-lane write enables
module sram_lane_array
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int LANES  = 8,
  parameter int DEPTH  = 16
) (
  input  wire logic I_CLOCK,
  sram_wr_if.mem    wr
);
  localparam int IDX_W = $clog2(DEPTH);
  logic [LANES*LANE_W-1:0] mem_r [DEPTH];
  logic [IDX_W-1:0]        idx;

  // Index is a plain slice of the address, so the depth must be a power of two
  if (DEPTH < 2 || DEPTH > (1 << ADDR_W) || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH out of range");
  end

  assign idx      = wr.addr[IDX_W-1:0];
  assign wr.rdata = mem_r[idx];

  // Storage carries no reset, as a real array would not
  always_ff @(posedge I_CLOCK) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr.we && wr.lane_en[l]) begin
        mem_r[idx][l*LANE_W +: LANE_W] <= wr.data[l*LANE_W +: LANE_W];
      end
    end
  end
endmodule

// ---- core/sram_ctl.sv ----
// Control-input logic of a pipelined burst SRAM
module sram_ctl
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF,
  parameter int DEPTH  = DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RST,
  // Control inputs
  input  wire logic                    i_clock_qualify_n,
  input  wire logic                    i_select,
  input  wire logic                    i_write_n,
  input  wire logic                    i_burst_step_or_load,
  input  wire logic [ADDR_W-1:0]       i_addr,
  input  wire logic [LANES-1:0]        i_byte_lane_write_select_n,
  // Data, each lane carries eight data bits and its parity_lane bit on top
  input  wire logic [LANES*LANE_W-1:0] i_data,
  output logic      [LANES*LANE_W-1:0] o_data,
  output logic                         o_data_valid,
  // Status
  output logic      [ADDR_W-1:0]       o_cur_addr,
  output logic                         o_active
);
  // Edge qualification
  logic                    qual;
  logic                    load_req;
  logic                    step_req;
  logic                    step_ok;

  // Access state group
  logic                    active_r;
  logic                    active_nxt;
  logic                    loaded_r;
  logic                    loaded_nxt;
  op_e                     op_r;
  op_e                     op_nxt;

  // Address group
  logic [ADDR_W-1:0]       base_r;
  logic [ADDR_W-1:0]       base_nxt;
  logic [BURST_W-1:0]      burst_r;
  logic [BURST_W-1:0]      burst_nxt;
  logic [BURST_W-1:0]      low_cur;
  logic [BURST_W-1:0]      low_next;
  logic [ADDR_W-1:0]       eff_addr;
  logic [ADDR_W-1:0]       step_addr;
  logic [ADDR_W-1:0]       wadr_r;
  logic [ADDR_W-1:0]       wadr_nxt;

  // Lane group
  logic [LANES-1:0]        lane_en_r;
  logic [LANES-1:0]        lane_en_nxt;

  // Read data group
  logic [LANES*LANE_W-1:0] dout_r;
  logic [LANES*LANE_W-1:0] dout_nxt;
  logic                    dval_r;
  logic                    dval_nxt;

  sram_wr_if #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES)
  ) wr ();

  // Elaboration-time checks on the parameters
  if (LANES < 1 || LANES > 8) begin : g_lanes_chk
    $error("LANES must be 1..8");
  end
  if (ADDR_W < BURST_W + 1) begin : g_addr_chk
    $error("ADDR_W too small");
  end

  assign qual     = !i_clock_qualify_n;
  assign load_req = qual && !i_burst_step_or_load;
  assign step_req = qual && i_burst_step_or_load;

  // Stepping after a deselect or before any load is refused
  assign step_ok  = step_req && active_r && loaded_r;

  // Burst counter wraps in the low address bits only, base bits stay put
  assign low_cur   = base_r[BURST_W-1:0] + burst_r;
  assign low_next  = low_cur + BURST_STEP;
  assign eff_addr  = {base_r[ADDR_W-1:BURST_W], low_cur};
  assign step_addr = {base_r[ADDR_W-1:BURST_W], low_next};

  // Access state: selection, load history and kind of access
  always_comb begin
    active_nxt = active_r;
    loaded_nxt = loaded_r;
    op_nxt     = op_r;
    if (load_req) begin
      active_nxt = i_select;
      if (i_select) begin
        loaded_nxt = 1'b1;
        op_nxt     = i_write_n ? OP_READ : OP_WRITE;
      end else begin
        op_nxt = OP_IDLE;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      active_r <= RST_ACTIVE;
      loaded_r <= RST_LOADED;
      op_r     <= OP_IDLE;
    end else begin
      active_r <= active_nxt;
      loaded_r <= loaded_nxt;
      op_r     <= op_nxt;
    end
  end

  // Address state: base, burst offset and the address of the pending access
  always_comb begin
    base_nxt  = base_r;
    burst_nxt = burst_r;
    wadr_nxt  = wadr_r;
    if (load_req && i_select) begin
      base_nxt  = i_addr;
      burst_nxt = RST_BURST;
      wadr_nxt  = i_addr;
    end else if (step_ok) begin
      // The stepped access works on the advanced address, not the current one
      burst_nxt = burst_r + BURST_STEP;
      wadr_nxt  = step_addr;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      base_r  <= '0;
      burst_r <= RST_BURST;
      wadr_r  <= '0;
    end else begin
      base_r  <= base_nxt;
      burst_r <= burst_nxt;
      wadr_r  <= wadr_nxt;
    end
  end

  // Lane strobes belong to the address phase of each qualified edge
  always_comb begin
    lane_en_nxt = lane_en_r;
    if (qual) begin
      lane_en_nxt = ~i_byte_lane_write_select_n;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      lane_en_r <= '0;
    end else begin
      lane_en_r <= lane_en_nxt;
    end
  end

  // Write data follows its address by one qualified edge, as on a pipelined part
  assign wr.we      = qual && (op_r == OP_WRITE) && active_r;
  assign wr.addr    = wadr_r;
  assign wr.lane_en = lane_en_r;
  assign wr.data    = i_data;

  always_comb begin
    dout_nxt = dout_r;
    dval_nxt = dval_r;
    if (qual) begin
      dval_nxt = (op_r == OP_READ) && active_r;
      if (dval_nxt) begin
        dout_nxt = wr.rdata;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      dout_r <= '0;
      dval_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      dval_r <= dval_nxt;
    end
  end

  sram_lane_array #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .DEPTH  (DEPTH)
  ) u_array (
    .I_CLOCK (I_CLOCK),
    .wr      (wr)
  );

  assign o_data       = dout_r;
  assign o_data_valid = dval_r;
  assign o_cur_addr   = eff_addr;
  assign o_active     = active_r;
endmodule

// ---- verification/sram_ctl_sva.sv ----
// Assertion checker for the SRAM control-input block
module sram_ctl_sva import sram_ctl_pkg::*; #(parameter int ADDR_W = 20, parameter int LANES = 8) (
  input wire logic I_CLOCK, I_RST, i_clock_qualify_n, i_select, i_write_n, i_burst_step_or_load,
  input wire logic [ADDR_W-1:0] i_addr, o_cur_addr,
  input wire logic o_data_valid, o_active,
  input wire logic [LANES*LANE_W-1:0] o_data
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  wire q = !i_clock_qualify_n;
  wire ld = q && !i_burst_step_or_load;
  property p_hold; !q |=> $stable(o_data) && $stable(o_cur_addr) && $stable(o_active) && $stable(o_data_valid); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved on a held edge");
  property p_load; ld && i_select |=> o_active && o_cur_addr == $past(i_addr); endproperty
  a_load: assert property (p_load) else $error("address not loaded");
  property p_step; q && i_burst_step_or_load && o_active |=> o_cur_addr[1:0] == $past(o_cur_addr[1:0]) + 2'h1
    && o_cur_addr[ADDR_W-1:2] == $past(o_cur_addr[ADDR_W-1:2]); endproperty
  a_step: assert property (p_step) else $error("burst counter did not advance");
  property p_idle; q && i_burst_step_or_load && !o_active |=> $stable(o_cur_addr); endproperty
  a_idle: assert property (p_idle) else $error("advance while deselected");
  property p_rd; ld && i_select && i_write_n ##1 q |=> o_data_valid; endproperty
  a_rd: assert property (p_rd) else $error("read data not valid");
  property p_wr; ld && i_select && !i_write_n ##1 q |=> !o_data_valid; endproperty
  a_wr: assert property (p_wr) else $error("write flagged read data");
  property p_fell; $fell(o_active) |-> $past(I_RST) || $past(ld && !i_select); endproperty
  a_fell: assert property (p_fell) else $error("deselect without a load");
  property p_desel; ld && !i_select |=> !o_active; endproperty
  a_desel: assert property (p_desel) else $error("deselect ignored");
  c_rd: cover property (ld && i_select && i_write_n);
  c_wr: cover property (ld && i_select && !i_write_n);
  c_step: cover property (q && i_burst_step_or_load && o_active);
endmodule
bind sram_ctl sram_ctl_sva #(.ADDR_W(ADDR_W), .LANES(LANES)) sram_ctl_sva_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .i_clock_qualify_n(i_clock_qualify_n), .i_select(i_select), .i_write_n(i_write_n),
  .i_burst_step_or_load(i_burst_step_or_load), .i_addr(i_addr), .o_cur_addr(o_cur_addr),
  .o_data_valid(o_data_valid), .o_active(o_active), .o_data(o_data));

// ---- verification/sram_host_model.sv ----
// Host controller model driving the SRAM control inputs
module sram_host_model import sram_ctl_pkg::*; (
  input  wire logic                        I_CLOCK,
  output logic      [3:0]                  o_ctl,
  output logic      [ADDR_W_DEF-1:0]       o_addr,
  output logic      [LANES_DEF-1:0]        o_bw_n,
  output logic      [LANES_DEF*LANE_W-1:0] o_dat
);
  timeunit 1ns;
  timeprecision 1ps;
  // Control bundle is {qualify_n, select, write_n, step}; starts unqualified
  initial begin
    o_ctl = 4'h8;
    o_addr = '0;
    o_bw_n = '1;
    o_dat = '0;
  end
  task automatic cyc(input logic [3:0] c, input logic [ADDR_W_DEF-1:0] a, input logic [LANES_DEF-1:0] b,
                     input logic [LANES_DEF*LANE_W-1:0] d);
    @(posedge I_CLOCK);
    o_ctl <= c;
    o_addr <= a;
    o_bw_n <= b;
    o_dat <= d;
  endtask
endmodule

// ---- verification/sram_ctl_tb_top.sv ----
// Self-checking testbench for the SRAM control-input block
module sram_ctl_tb_top import sram_ctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = LANES_DEF*LANE_W;
  localparam logic [3:0] WR = 4'h4, RD = 4'h6, AD = 4'h7, HL = 4'h8, DS = 4'h2;
  logic I_CLOCK = 1'b0, I_RST = 1'b1;
  logic [3:0] ctl;
  logic dv, act;
  logic [19:0] ad, ca;
  logic [7:0] bw;
  logic [DW-1:0] di, dq, ex;
  logic [DW-1:0] d1 = 72'h123456789abcdef012, d2 = 72'h0fedcba9876543210f;
  int n_mismatch = 0, tests_run = 0;
  sram_ctl sram_ctl_inst (.I_CLOCK, .I_RST, .i_clock_qualify_n(ctl[3]), .i_select(ctl[2]), .i_write_n(ctl[1]),
    .i_burst_step_or_load(ctl[0]), .i_addr(ad), .i_byte_lane_write_select_n(bw), .i_data(di), .o_data(dq),
    .o_data_valid(dv), .o_cur_addr(ca), .o_active(act));
  sram_host_model sram_host_model_inst (.I_CLOCK, .o_ctl(ctl), .o_addr(ad), .o_bw_n(bw), .o_dat(di));
  initial forever #4 I_CLOCK = ~I_CLOCK;
  task chk(string s, logic [DW-1:0] e, logic [DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task c(logic [3:0] k, logic [19:0] a, logic [7:0] b, logic [DW-1:0] d);
    sram_host_model_inst.cyc(k, a, b, d);
    #1;
  endtask
  task t_lanes;
    c(WR, 20'h5, 8'h00, ~d1);
    c(WR, 20'h5, 8'h5a, d1);
    c(RD, 20'h5, 8'h00, d2);
    c(RD, 20'h5, 8'h00, ~d2);
    c(HL, 20'h5, 8'h00, ~d2);
    for (int l = 0; l < 8; l++) ex[9*l+:9] = (8'h5a >> l) & 8'h01 ? d1[9*l+:9] : d2[9*l+:9];
    chk("lanes", ex, dq);
    chk("valid", 1, DW'(dv));
  endtask
  task t_hold;
    c(WR, 20'h7, 8'h00, ~d2);
    repeat (3) c(HL, 20'h9, 8'h00, ~d1);
    chk("held", ex, dq);
    chk("kept", 1, DW'(act));
    c(RD, 20'h7, 8'h00, d1);
    c(RD, 20'h7, 8'h00, ~d1);
    c(HL, 20'h7, 8'h00, ~d1);
    chk("hdata", d1, dq);
  endtask
  task t_burst;
    c(WR, 20'ha, 8'h00, ~d1);
    c(AD, 20'hfffff, 8'h00, d1);
    chk("ld", 20'ha, ca);
    c(AD, 20'hfffff, 8'h00, d2);
    chk("st", 20'hb, ca);
    c(RD, 20'ha, 8'h00, d1 ^ d2);
    chk("wrap", 20'h8, ca);
    c(AD, 20'h0, 8'h00, ~d2);
    c(AD, 20'h0, 8'h00, ~d2);
    chk("b0", d1, dq);
    c(RD, 20'h0, 8'h00, ~d2);
    chk("b1", d2, dq);
    c(HL, 20'h0, 8'h00, ~d2);
    chk("b2", d1 ^ d2, dq);
  endtask
  task t_desel;
    c(DS, 20'h3, 8'h00, ~d1);
    c(AD, 20'h3, 8'h00, ~d1);
    chk("desel", 0, DW'(act));
    c(RD, 20'h4, 8'h00, ~d1);
    c(HL, 20'h4, 8'h00, ~d1);
    chk("resel", DW'({ca, act}), DW'({20'h4, 1'b1}));
  endtask
  task give_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // The tests need under 100 cycles, so 20 us means a hang
  initial begin
    #20us;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    #1;
    chk("rst", 0, dq | DW'({ca, dv, act}));
    t_lanes;
    t_hold;
    t_burst;
    t_desel;
    give_verdict;
  end
endmodule
